// >>> inc/sbc_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 25 MHz pclk and a 100 kHz two-wire bus
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// apb byte addresses
`define SBC_CTRL_ADDR 12'h000
`define SBC_STAT_ADDR 12'h004
`define SBC_RXD_ADDR 12'h008

// control field positions
`define SBC_START_BIT 0
`define SBC_RSTART_BIT 1
`define SBC_STOP_BIT 2
`define SBC_RECV_BIT 3
`define SBC_ACKSEQ_BIT 4
`define SBC_ACKVAL_BIT 5
`define SBC_STRETCH_BIT 6
`define SBC_RELEASE_BIT 12

// control reset value, plain read/write bits and trigger bits
`define SBC_CTRL_RESET 16'h1000
`define SBC_CTRL_RWMASK 16'h1060
`define SBC_TRIG_MASK 16'h001F

// status field positions
`define SBC_ST_BUSY_BIT 0
`define SBC_ST_OWN_BIT 1
`define SBC_ST_AVAIL_BIT 2
`define SBC_ST_FULL_BIT 3
`define SBC_RXD_VALID_BIT 8

// quarter bit time, least time, rounded up to whole cycles
`define SBC_CLK_NS 40
`define SBC_QTR_NS 2500
`define SBC_QTR_CYC ((`SBC_QTR_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)

// receive buffer shape
`define SBC_FIFO_WIDTH 8
`define SBC_FIFO_DEPTH 16

`endif

// >>> inc/sbc_pkg.sv
// types shared by the serial bus sequencer
// assumes sbc_defines.svh for all numeric constants
`default_nettype none

package sbc_pkg;

	// bus sequence being played
	typedef enum logic [2:0] {
		sbc_idle = 3'b000,
		sbc_start = 3'b001,
		sbc_rstart = 3'b010,
		sbc_stop = 3'b011,
		sbc_recv = 3'b100,
		sbc_ack = 3'b101
	} sbc_state_type;

	// quarter-bit phase within a sequence step
	typedef logic [1:0] sbc_phase_type;

endpackage : sbc_pkg

`default_nettype wire

// >>> verilog/sbc_fifo.sv
// receive buffer: synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module sbc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wptr_reg;
	logic [AW:0] wptr_next;
	logic [AW:0] rptr_reg;
	logic [AW:0] rptr_next;
	logic push;
	logic pop;

	// full when pointers differ only in the wrap bit
	assign in_ready = (wptr_reg ^ rptr_reg) != {1'b1, {AW{1'b0}}};
	assign out_valid = wptr_reg != rptr_reg;
	assign out_data = mem_reg[rptr_reg[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer advance
	always_comb begin
		wptr_next = wptr_reg + (AW+1)'(push);
		rptr_next = rptr_reg + (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
		end
	end

	// storage, written only on push
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wptr_reg[AW-1:0]] <= in_data;
		end
	end

endmodule : sbc_fifo

`default_nettype wire

// >>> verilog/sbc_sequencer.sv
// two-wire bus master sequencer with control, status and rx registers
// assumes an apb master on pclk and open-drain pads outside
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defines.svh"

// What this block does
// - slave mode: stretch-enable 1 holds clock low until released; 0 never
// - ack-value bit is driven in ack slot: 1 sends nack, 0 ack
// - ack trigger plays ack sequence, hardware clears it when done
// - receive trigger clocks in one byte, cleared after eighth bit
// - stop trigger plays a stop condition, cleared when it ends
// - repeated-start trigger plays repeated start, cleared at its end
// - start trigger plays a start condition, cleared at its end
module sbc_sequencer
	import sbc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	localparam logic [6:0] QTR_LAST = 7'(`SBC_QTR_CYC - 1);

	// apb slave state
	logic pready_reg;
	logic pready_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic acc;
	logic done_wr;
	logic done_rd;
	logic hit;

	// control and sequencer state
	logic [15:0] ctl_reg;
	logic [15:0] ctl_next;
	sbc_state_type state_reg;
	sbc_state_type state_next;
	sbc_phase_type phase_reg;
	sbc_phase_type phase_next;
	logic [6:0] qcnt_reg;
	logic [6:0] qcnt_next;
	logic [2:0] bit_reg;
	logic [2:0] bit_next;
	logic [7:0] shift_reg;
	logic [7:0] shift_next;
	logic ackl_reg;
	logic ackl_next;
	logic own_reg;
	logic own_next;
	logic scl_oe_reg;
	logic scl_oe_next;
	logic sda_oe_reg;
	logic sda_oe_next;
	logic tick;
	logic adv;
	logic done;
	logic push;

	// receive buffer wires
	logic rx_ready;
	logic rx_valid;
	logic rx_pop;
	logic [7:0] rx_data;

	assign acc = psel && penable;
	assign done_wr = acc && pready_reg && pwrite;
	assign done_rd = acc && pready_reg && !pwrite;
	assign hit = paddr == `SBC_CTRL_ADDR || paddr == `SBC_STAT_ADDR
		|| paddr == `SBC_RXD_ADDR;
	assign rx_pop = done_rd && paddr == `SBC_RXD_ADDR && rx_valid;

	// apb answer one cycle into the access phase
	always_comb begin
		pready_next = acc && !pready_reg;
		pslverr_next = 1'b0;
		prdata_next = 32'h0000_0000;
		if (acc && !pready_reg) begin
			pslverr_next = !hit;
			if (!pwrite) begin
				if (paddr == `SBC_CTRL_ADDR) begin
					prdata_next = {16'h0000, ctl_reg};
				end else if (paddr == `SBC_STAT_ADDR) begin
					prdata_next[`SBC_ST_BUSY_BIT] = state_reg != sbc_idle;
					prdata_next[`SBC_ST_OWN_BIT] = own_reg;
					prdata_next[`SBC_ST_AVAIL_BIT] = rx_valid;
					prdata_next[`SBC_ST_FULL_BIT] = !rx_ready;
				end else if (paddr == `SBC_RXD_ADDR) begin
					prdata_next[7:0] = rx_valid ? rx_data : 8'h00;
					prdata_next[`SBC_RXD_VALID_BIT] = rx_valid;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// quarter-bit timing and sequence completion
	assign tick = qcnt_reg == QTR_LAST;
	assign adv = tick && !(phase_reg == 2'd1 && !scl_in
		&& (state_reg == sbc_recv || state_reg == sbc_ack));
	always_comb begin
		done = 1'b0;
		unique case (state_reg)
			sbc_idle: done = 1'b0;
			sbc_start, sbc_stop: done = adv && phase_reg == 2'd2;
			sbc_rstart, sbc_ack: done = adv && phase_reg == 2'd3;
			sbc_recv: done = adv && phase_reg == 2'd3 && bit_reg == 3'd7;
		endcase
	end
	assign push = done && state_reg == sbc_recv;

	// control register: hardware clear, then software set wins
	always_comb begin
		ctl_next = ctl_reg;
		if (done) begin
			unique case (state_reg)
				sbc_start: ctl_next[`SBC_START_BIT] = 1'b0;
				sbc_rstart: ctl_next[`SBC_RSTART_BIT] = 1'b0;
				sbc_stop: ctl_next[`SBC_STOP_BIT] = 1'b0;
				sbc_recv: ctl_next[`SBC_RECV_BIT] = 1'b0;
				sbc_ack: ctl_next[`SBC_ACKSEQ_BIT] = 1'b0;
				sbc_idle: ctl_next = ctl_reg;
			endcase
		end
		if (done_wr && paddr == `SBC_CTRL_ADDR) begin
			ctl_next = (ctl_next & ~`SBC_CTRL_RWMASK)
				| (pwdata[15:0] & `SBC_CTRL_RWMASK)
				| (pwdata[15:0] & `SBC_TRIG_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_reg <= `SBC_CTRL_RESET;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// sequence dispatch and stepping
	always_comb begin
		state_next = state_reg;
		phase_next = phase_reg;
		qcnt_next = (state_reg == sbc_idle || tick) ? 7'd0 : qcnt_reg + 7'd1;
		bit_next = bit_reg;
		shift_next = shift_reg;
		ackl_next = ackl_reg;
		own_next = own_reg;
		if (adv && state_reg == sbc_recv && phase_reg == 2'd2) begin
			shift_next = {shift_reg[6:0], sda_in};
		end
		if (qcnt_reg == QTR_LAST && !adv) begin
			qcnt_next = qcnt_reg; // slave holds clock low
		end
		if (state_reg == sbc_idle) begin
			phase_next = 2'd0;
			bit_next = 3'd0;
			if (ctl_reg[`SBC_START_BIT]) begin
				state_next = sbc_start;
			end else if (ctl_reg[`SBC_RSTART_BIT]) begin
				state_next = sbc_rstart;
			end else if (ctl_reg[`SBC_STOP_BIT]) begin
				state_next = sbc_stop;
			end else if (ctl_reg[`SBC_RECV_BIT] && rx_ready) begin
				state_next = sbc_recv;
			end else if (ctl_reg[`SBC_ACKSEQ_BIT]) begin
				state_next = sbc_ack;
				ackl_next = ctl_reg[`SBC_ACKVAL_BIT];
			end
		end else if (done) begin
			state_next = sbc_idle;
			if (state_reg == sbc_start || state_reg == sbc_rstart) begin
				own_next = 1'b1;
			end else if (state_reg == sbc_stop) begin
				own_next = 1'b0;
			end
		end else if (adv) begin
			phase_next = phase_reg + 2'd1;
			if (phase_reg == 2'd3) begin
				bit_next = bit_reg + 3'd1;
			end
		end
	end

	// pad drive, high enable pulls the line low
	always_comb begin
		scl_oe_next = 1'b0;
		sda_oe_next = 1'b0;
		unique case (state_reg)
			sbc_idle: begin
				scl_oe_next = own_reg || (ctl_reg[`SBC_STRETCH_BIT]
					&& !ctl_reg[`SBC_RELEASE_BIT]);
			end
			sbc_start: begin
				sda_oe_next = phase_reg != 2'd0;
				scl_oe_next = phase_reg == 2'd2;
			end
			sbc_rstart: begin
				sda_oe_next = phase_reg == 2'd2 || phase_reg == 2'd3;
				scl_oe_next = phase_reg == 2'd0 || phase_reg == 2'd3;
			end
			sbc_stop: begin
				sda_oe_next = phase_reg != 2'd2;
				scl_oe_next = phase_reg == 2'd0;
			end
			sbc_recv: begin
				scl_oe_next = phase_reg == 2'd0 || phase_reg == 2'd3;
			end
			sbc_ack: begin
				sda_oe_next = !ackl_reg;
				scl_oe_next = phase_reg == 2'd0 || phase_reg == 2'd3;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= sbc_idle;
			phase_reg <= 2'd0;
			qcnt_reg <= 7'd0;
			bit_reg <= 3'd0;
			shift_reg <= 8'h00;
			ackl_reg <= 1'b0;
			own_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			qcnt_reg <= qcnt_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			ackl_reg <= ackl_next;
			own_reg <= own_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
		end
	end

	// received bytes wait here until software reads them
	sbc_fifo #(
		.WIDTH(`SBC_FIFO_WIDTH),
		.DEPTH(`SBC_FIFO_DEPTH)
	) u_rx_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.in_valid(push),
		.in_ready(rx_ready),
		.in_data(shift_reg),
		.out_valid(rx_valid),
		.out_ready(rx_pop),
		.out_data(rx_data)
	);

	// outputs straight from flops, pad data tied low so pads only ever pull low
	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign scl_oe = scl_oe_reg;
	assign sda_oe = sda_oe_reg;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;

	// checks
	property p_stretch;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_idle && !own_reg
		|=> scl_oe_reg == $past(ctl_reg[`SBC_STRETCH_BIT]
			&& !ctl_reg[`SBC_RELEASE_BIT]);
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("stretch drive does not follow enable and release");

	// ack slot drive must follow the ack value seen at dispatch
	property p_ackval;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_ack && $past(state_reg) == sbc_idle
		|=> sda_oe_reg == !$past(ctl_reg[`SBC_ACKVAL_BIT], 2);
	endproperty
	a_ackval: assert property (p_ackval)
		else $error("ack slot does not carry the ack value");

	property p_ackclr;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_ack && done && !done_wr
		|=> !ctl_reg[`SBC_ACKSEQ_BIT] && state_reg == sbc_idle;
	endproperty
	a_ackclr: assert property (p_ackclr)
		else $error("ack trigger not cleared at sequence end");

	property p_recvclr;
		@(posedge pclk) disable iff (!presetn)
		$fell(ctl_reg[`SBC_RECV_BIT])
		|-> $past(state_reg) == sbc_recv && $past(bit_reg) == 3'd7;
	endproperty
	a_recvclr: assert property (p_recvclr)
		else $error("receive trigger cleared before eighth bit");

	property p_stopclr;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_stop && done && !done_wr
		|=> !ctl_reg[`SBC_STOP_BIT] && !own_reg && !sda_oe_reg;
	endproperty
	a_stopclr: assert property (p_stopclr)
		else $error("stop trigger not cleared or bus not freed");

	property p_rstart;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_idle && ctl_reg[`SBC_RSTART_BIT]
		&& !ctl_reg[`SBC_START_BIT]
		|=> state_reg == sbc_rstart ##1 state_reg == sbc_rstart;
	endproperty
	a_rstart: assert property (p_rstart)
		else $error("repeated start not dispatched");

	property p_startclr;
		@(posedge pclk) disable iff (!presetn)
		$fell(ctl_reg[`SBC_START_BIT])
		|-> $past(state_reg) == sbc_start && $past(phase_reg) == 2'd2;
	endproperty
	a_startclr: assert property (p_startclr)
		else $error("start trigger cleared outside start end");

	property p_busy;
		@(posedge pclk) disable iff (!presetn)
		state_reg == sbc_start |-> ctl_reg[`SBC_START_BIT];
	endproperty
	a_busy: assert property (p_busy)
		else $error("start sequence running with trigger low");

endmodule : sbc_sequencer

`default_nettype wire

// >>> test/sbc_slave_model.sv
// far-side slave model: sends one byte msb first, may stretch the clock
// assumes open-drain wires resolved in the bench; a drive of 1 is released
`timescale 1ns/1ns
`default_nettype none

module sbc_slave_model (
	input wire logic pclk,
	input wire logic scl_w,
	input wire logic scl_oe,
	input wire logic load,
	input wire logic [7:0] tx_byte,
	input wire logic [15:0] stretch_cyc,
	output logic scl_drv,
	output logic sda_drv
);
	logic [7:0] shift_reg;
	logic scl_q;
	int left;
	int hold;

	// idle state: nothing to send, lines released
	initial begin
		shift_reg = 8'h00;
		scl_q = 1'b1;
		left = 0;
		hold = 0;
	end

	// next bit after each falling clock edge, stretch count reloaded
	always @(posedge pclk) begin
		scl_q <= scl_w;
		if (load) begin
			shift_reg <= tx_byte;
			left <= 8;
			hold <= int'(stretch_cyc);
		end else if (scl_q && !scl_w && left > 0) begin
			shift_reg <= {shift_reg[6:0], 1'b1};
			left <= left - 1;
			hold <= int'(stretch_cyc);
		end else if (hold > 0 && !scl_oe) begin
			hold <= hold - 1;
		end
	end

	// hold clock low after master lets go; release data after 8 bits
	assign scl_drv = !(left > 0 && hold > 0 && !scl_oe);
	assign sda_drv = (left > 0) ? shift_reg[7] : 1'b1;

endmodule : sbc_slave_model
`default_nettype wire

// >>> test/test_i2c_bus_sequence_control.sv
// self-checking bench for the two-wire sequencer behind its apb registers
// assumes sbc_slave_model on the far side and pull-ups on both lines
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defines.svh"

module test_i2c_bus_sequence_control;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic scl_out, scl_oe, sda_out, sda_oe, scl_drv, sda_drv, scl_w, sda_w;
	logic load, er, last_bit;
	logic [7:0] tx_byte;
	logic [15:0] stretch_cyc;
	int fails, total_checks, n_start, n_stop, seed;
	int q[$];

	// wire resolution: pulled up unless a party pulls low
	assign scl_w = (scl_oe ? scl_out : 1'b1) & scl_drv;
	assign sda_w = (sda_oe ? sda_out : 1'b1) & sda_drv;

	sbc_sequencer u_sbc_sequencer (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe));

	sbc_slave_model u_sbc_slave_model (.pclk(pclk), .scl_w(scl_w),
		.scl_oe(scl_oe), .load(load), .tx_byte(tx_byte),
		.stretch_cyc(stretch_cyc), .scl_drv(scl_drv), .sda_drv(sda_drv));

	// clock, 40 ns period
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// start/stop counters and the bit seen at each clock rise
	always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
	always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;
	always @(posedge scl_w) last_bit = sda_w;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: reg %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_line(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: line %b exp %b", $time, got, exp);
		end
	endtask : chk_line

	// one apb transfer, held until pready, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// set one trigger, then poll until hardware clears it
	task automatic trig(input logic [31:0] v, input logic [31:0] m);
		int n;
		n = 0;
		apb(1'b1, `SBC_CTRL_ADDR, v);
		do begin
			apb(1'b0, `SBC_CTRL_ADDR, 32'h0);
			n++;
		end while ((rv & m) != 0 && n < 3000);
		chk_reg(rv & m, 32'h0);
	endtask : trig

	initial begin
		seed = 85272;
		{fails, total_checks, n_start, n_stop} = '0;
		{presetn, psel, penable, pwrite, load} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		tx_byte = 8'h00;
		stretch_cyc = 16'h0000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		n_start = 0;
		n_stop = 0;
		// reset value, unmapped access refused
		apb(1'b0, `SBC_CTRL_ADDR, 32'h0);
		chk_reg(rv, 32'h0000_1000);
		apb(1'b0, 12'hFF0, 32'h0);
		chk_reg({er, rv[30:0]}, 32'h8000_0000);
		// idle stretch follows enable and release
		apb(1'b1, `SBC_CTRL_ADDR, 32'h0000_0040);
		repeat (3) @(posedge pclk);
		chk_line(scl_w, 1'b0);
		apb(1'b1, `SBC_CTRL_ADDR, 32'h0000_1040);
		repeat (3) @(posedge pclk);
		chk_line(scl_w, 1'b1);
		$display("test idle stretch done");
		trig(32'h0000_1001, 32'h1);
		chk_reg(32'(n_start), 32'h1);
		$display("test start done");
		// seventeen bytes, the last stalls on a full buffer
		for (int i = 0; i < 17; i++) begin
			tx_byte <= 8'($random(seed));
			stretch_cyc <= (i == 0) ? 16'h0064 : 16'h0000;
			load <= 1'b1;
			@(posedge pclk);
			load <= 1'b0;
			q.push_back(int'(tx_byte));
			if (i < 16) trig(32'h0000_1048, 32'h8);
			else apb(1'b1, `SBC_CTRL_ADDR, 32'h0000_1048);
		end
		repeat (2500) @(posedge pclk);
		apb(1'b0, `SBC_CTRL_ADDR, 32'h0);
		chk_reg(rv & 32'h8, 32'h8);
		apb(1'b0, `SBC_STAT_ADDR, 32'h0);
		chk_reg(rv & 32'hE, 32'hE);
		for (int i = 0; i < 17; i++) begin
			apb(1'b0, `SBC_RXD_ADDR, 32'h0);
			chk_reg(rv, 32'h100 | 32'(q.pop_front()));
			if (i == 0) trig(32'h0000_1040, 32'h8);
		end
		apb(1'b0, `SBC_RXD_ADDR, 32'h0);
		chk_line(rv[8], 1'b0);
		$display("test receive done");
		trig(32'h0000_1010, 32'h10);
		chk_line(last_bit, 1'b0);
		trig(32'h0000_1030, 32'h10);
		chk_line(last_bit, 1'b1);
		$display("test ack done");
		trig(32'h0000_1002, 32'h2);
		chk_reg(32'(n_start), 32'h2);
		trig(32'h0000_1004, 32'h4);
		chk_reg(32'(n_stop), 32'h1);
		apb(1'b0, `SBC_STAT_ADDR, 32'h0);
		chk_reg(rv & 32'h2, 32'h0);
		$display("test rstart stop done");
		end_of_test();
	end

	// watchdog against a hung sequence
	initial begin
		#(90000 * 40);
		fails++;
		end_of_test();
	end

endmodule : test_i2c_bus_sequence_control
`default_nettype wire
